//--- include/pcm_pkg.sv
// Constants for the one-wire pulse-count mode selector.
// Assumes a 40 MHz system clock; times are converted to cycles here.
package pcm_pkg;
  localparam int unsigned CLK_HZ          = 40000000;
  localparam int unsigned DEGLITCH_NS     = 2000;
  localparam int unsigned DEGLITCH_CYC    = (DEGLITCH_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned IDLE_US         = 500;
  localparam int unsigned IDLE_CYC        = IDLE_US * (CLK_HZ / 1000000);
  localparam int unsigned OFF_HOLD_US     = 800;
  localparam int unsigned OFF_HOLD_CYC    = OFF_HOLD_US * (CLK_HZ / 1000000);
  localparam int unsigned RAMP_US         = 100;
  localparam int unsigned RAMP_CYC        = RAMP_US * (CLK_HZ / 1000000);
  localparam int unsigned MAX_EDGES       = 4;
  localparam logic [2:0]  MODE_RESET      = 3'h0;
  localparam logic [1:0]  PLIMIT_1W2      = 2'h0;
  localparam logic [1:0]  PLIMIT_1W0      = 2'h1;
  localparam logic [1:0]  PLIMIT_0W8      = 2'h2;
  localparam logic [1:0]  PLIMIT_0W6      = 2'h3;

  typedef enum logic [2:0] {
    PCM_OFF    = 3'b000,
    PCM_COUNT  = 3'b001,
    PCM_RAMPUP = 3'b011,
    PCM_ON     = 3'b010,
    PCM_RAMPDN = 3'b110,
    PCM_FAULT  = 3'b111
  } pcm_state_t;
endpackage

//--- src/pcm_deglitch.sv
// Deglitch filter for the shutdown control pin.
// Assumes the pin is synchronous to clk; output changes only after a stable run.
`timescale 1ns/10ps
module pcm_deglitch
  import pcm_pkg::*;
#(
  parameter int unsigned STABLE_CYC = DEGLITCH_CYC
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic pin_in,
  output logic      pin_clean
);
  localparam int unsigned CW = $clog2(STABLE_CYC + 1);

  logic [CW-1:0] cnt_r;

  if (STABLE_CYC < 1) begin : g_bad_stable
    $error("pcm_deglitch: STABLE_CYC must be at least 1");
  end

  // Pin must differ from the filtered level for STABLE_CYC cycles
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r     <= '0;
      pin_clean <= 1'b0;
    end else if (pin_in == pin_clean) begin
      cnt_r <= '0;
    end else if (cnt_r == CW'(STABLE_CYC - 1)) begin
      cnt_r     <= '0;
      pin_clean <= pin_in;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule

//--- src/pcm_mode_select.sv
// One-wire pulse-count mode selector with fault shutdown and pop-free sequencing.
// Assumes shutdown_ctrl_pin and fault inputs are synchronous to clk.
`timescale 1ns/10ps
module pcm_mode_select
  import pcm_pkg::*;
#(
  parameter int unsigned IDLE_CYCLES = IDLE_CYC,
  parameter int unsigned OFF_CYCLES  = OFF_HOLD_CYC,
  parameter int unsigned RAMP_CYCLES = RAMP_CYC,
  parameter int unsigned EDGE_MAX    = MAX_EDGES
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       shutdown_ctrl_pin,
  input  wire logic       overcurrent_guard,
  input  wire logic       overtemp_guard,
  output logic [2:0]      mode_r,
  output logic [1:0]      power_limit_r,
  output logic            no_crack_agc_r,
  output logic            amp_enable_r,
  output logic            output_mute_r,
  output logic            fault_active_r
);
  localparam int unsigned TW = $clog2(((IDLE_CYCLES > OFF_CYCLES) ? IDLE_CYCLES : OFF_CYCLES)
                                      + RAMP_CYCLES + 1);

  // Edge counter is three bits wide; timers need a nonzero length
  if (EDGE_MAX < 1 || EDGE_MAX > 7) begin : g_bad_edge_max
    $error("pcm_mode_select: EDGE_MAX out of range");
  end
  if (IDLE_CYCLES < 1 || OFF_CYCLES < 1 || RAMP_CYCLES < 1) begin : g_bad_timing
    $error("pcm_mode_select: timing counts must be at least 1");
  end

  function automatic logic [1:0] limit_of(input logic [2:0] m);
    case (m)
      3'h1:    limit_of = PLIMIT_1W2;
      3'h2:    limit_of = PLIMIT_1W0;
      3'h3:    limit_of = PLIMIT_0W8;
      default: limit_of = PLIMIT_0W6;
    endcase
  endfunction

  // Amplifier stage is powered while ramping or running
  function automatic logic powered(input pcm_state_t s);
    case (s)
      PCM_RAMPUP, PCM_ON, PCM_RAMPDN: powered = 1'b1;
      default:                        powered = 1'b0;
    endcase
  endfunction

  // Rising edges count only from shutdown and while a train is open
  function automatic logic listening(input pcm_state_t s);
    case (s)
      PCM_OFF, PCM_COUNT: listening = 1'b1;
      default:            listening = 1'b0;
    endcase
  endfunction

  logic          pin_f;
  logic          pin_d_r;
  logic          rise;
  logic          rise_pend_r;
  logic          take_edge;
  logic          fault;
  logic [TW-1:0] hi_cnt_r;
  logic [TW-1:0] lo_cnt_r;
  logic [TW-1:0] ramp_cnt_r;
  logic [2:0]    edges_r;
  logic          off_hold;
  logic          idle_done;
  logic          ramp_done;
  pcm_state_t    state_r;
  pcm_state_t    state_nxt;

  pcm_deglitch u_deglitch (
    .clk       (clk),
    .reset_n   (reset_n),
    .pin_in    (shutdown_ctrl_pin),
    .pin_clean (pin_f)
  );

  assign rise      = pin_f & ~pin_d_r;
  assign take_edge = rise | rise_pend_r;
  assign fault     = overcurrent_guard | overtemp_guard;
  assign off_hold  = ~pin_f && (lo_cnt_r >= TW'(OFF_CYCLES));
  assign idle_done = pin_f && (hi_cnt_r >= TW'(IDLE_CYCLES));
  assign ramp_done = (ramp_cnt_r >= TW'(RAMP_CYCLES));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_d_r <= 1'b0;
    end else begin
      pin_d_r <= pin_f;
    end
  end

  // A rise seen during ramp-down already follows a full off-hold, so it is
  // kept and counted once shutdown is reached instead of being lost
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rise_pend_r <= 1'b0;
    end else if (state_r == PCM_RAMPDN) begin
      if (rise) rise_pend_r <= 1'b1;
    end else begin
      rise_pend_r <= 1'b0;
    end
  end

  // High and low run-length timers on the filtered pin
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hi_cnt_r <= '0;
      lo_cnt_r <= '0;
    end else begin
      if (!pin_f) hi_cnt_r <= '0;
      else if (!idle_done) hi_cnt_r <= hi_cnt_r + 1'b1;
      if (pin_f) lo_cnt_r <= '0;
      else if (!off_hold) lo_cnt_r <= lo_cnt_r + 1'b1;
    end
  end

  // Edge counter, active only while a train is being received
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      edges_r <= '0;
    end else if (off_hold) begin
      edges_r <= '0;
    end else if (listening(state_r) && take_edge) begin
      if (edges_r < 3'(EDGE_MAX)) edges_r <= edges_r + 1'b1;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PCM_OFF: begin
        if (take_edge) state_nxt = PCM_COUNT;
      end
      PCM_COUNT: begin
        if (off_hold) state_nxt = PCM_OFF;
        else if (idle_done) state_nxt = PCM_RAMPUP;
      end
      PCM_RAMPUP: begin
        if (fault) state_nxt = PCM_FAULT;
        else if (off_hold) state_nxt = PCM_RAMPDN;
        else if (ramp_done) state_nxt = PCM_ON;
      end
      PCM_ON: begin
        if (fault) state_nxt = PCM_FAULT;
        else if (off_hold) state_nxt = PCM_RAMPDN;
      end
      PCM_RAMPDN: begin
        if (ramp_done) state_nxt = PCM_OFF;
      end
      PCM_FAULT: begin
        if (off_hold) state_nxt = PCM_OFF;
        else if (!fault) state_nxt = PCM_RAMPUP;
      end
      default: state_nxt = PCM_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= PCM_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Ramp timer restarts on every state change
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ramp_cnt_r <= '0;
    end else if (state_nxt != state_r) begin
      ramp_cnt_r <= '0;
    end else if (!ramp_done) begin
      ramp_cnt_r <= ramp_cnt_r + 1'b1;
    end
  end

  // Mode latch: loaded once when the train completes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_r        <= MODE_RESET;
      power_limit_r <= PLIMIT_1W2;
    end else if (state_r == PCM_OFF) begin
      mode_r <= MODE_RESET;
    end else if (state_r == PCM_COUNT && state_nxt == PCM_RAMPUP) begin
      mode_r        <= edges_r;
      power_limit_r <= limit_of(edges_r);
    end
  end

  // Amplifier controls from state; mute leads enable on the way down
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      amp_enable_r   <= 1'b0;
      output_mute_r  <= 1'b1;
      no_crack_agc_r <= 1'b0;
      fault_active_r <= 1'b0;
    end else begin
      amp_enable_r   <= powered(state_nxt);
      output_mute_r  <= (state_nxt != PCM_ON);
      no_crack_agc_r <= (state_nxt == PCM_ON) || (state_nxt == PCM_RAMPUP);
      fault_active_r <= (state_nxt == PCM_FAULT);
    end
  end
endmodule

//--- tb/pcm_mode_select_properties.sv
// Port checker for the pulse-count mode selector.
// Bound onto pcm_mode_select; one clock, async active-low reset.
`timescale 1ns/10ps
module pcm_mode_select_properties (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       shutdown_ctrl_pin,
  input wire logic       overcurrent_guard,
  input wire logic       overtemp_guard,
  input wire logic [2:0] mode_r,
  input wire logic [1:0] power_limit_r,
  input wire logic       no_crack_agc_r,
  input wire logic       amp_enable_r,
  input wire logic       output_mute_r,
  input wire logic       fault_active_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_on2; mode_r != 3'h0 ##1 mode_r != 3'h0; endsequence
  sequence s_sel; mode_r == 3'h0 ##1 mode_r != 3'h0; endsequence
  property p_range; mode_r <= 3'h4; endproperty
  a_range: assert property (p_range) else $error("mode high");
  property p_lim; mode_r != 3'h0 |-> {1'b0, power_limit_r} == mode_r - 3'h1; endproperty
  a_lim: assert property (p_lim) else $error("limit");
  property p_latch; s_on2 |-> $stable(mode_r); endproperty
  a_latch: assert property (p_latch) else $error("latch");
  property p_sel; s_sel |-> shutdown_ctrl_pin && amp_enable_r && no_crack_agc_r; endproperty
  a_sel: assert property (p_sel) else $error("select");
  property p_flt;
    (overcurrent_guard || overtemp_guard) && !output_mute_r |=> !amp_enable_r && fault_active_r;
  endproperty
  a_flt: assert property (p_flt) else $error("fault");
  property p_mute; !amp_enable_r |-> output_mute_r; endproperty
  a_mute: assert property (p_mute) else $error("mute");
  property p_ramp; $rose(amp_enable_r) |-> output_mute_r [*8]; endproperty
  a_ramp: assert property (p_ramp) else $error("ramp");
  property p_unmute; $fell(output_mute_r) |-> amp_enable_r && $past(amp_enable_r, 8); endproperty
  a_unmute: assert property (p_unmute) else $error("unmute");
endmodule
bind pcm_mode_select pcm_mode_select_properties pcm_mode_select_properties_i (.*);

//--- tb/pcm_host.sv
// Host GPIO model driving the one-wire pulse train.
// Assumes the caller waits for the selector between trains.
`timescale 1ns/10ps
module pcm_host (
  input  wire logic clk,
  output logic      pin
);
  initial pin = 1'b0;
  // N rises, high hi and low lo cycles, left high
  task automatic pulses(input int n, input int hi, input int lo);
    for (int i = 0; i < n; i++) begin
      @(posedge clk) pin <= 1'b1;
      if (i < n - 1) begin
        repeat (hi) @(posedge clk);
        pin <= 1'b0;
        repeat (lo - 1) @(posedge clk);
      end
    end
  endtask
  task automatic off(input int hold);
    @(posedge clk) pin <= 1'b0;
    repeat (hold) @(posedge clk);
  endtask
endmodule

//--- tb/tb_top.sv
// Testbench for the pulse-count mode selector with a host model.
// Assumes 40 MHz clock and shortened idle, off-hold and ramp counts.
`timescale 1ns/10ps
module tb_top;
  logic       clk, reset_n, shutdown_ctrl_pin, overcurrent_guard, overtemp_guard;
  logic [2:0] mode_r;
  logic [1:0] power_limit_r;
  logic       no_crack_agc_r, amp_enable_r, output_mute_r, fault_active_r;
  int         error_cnt = 0;
  int         tests_run = 0;
  int         cyc = 0;
  pcm_mode_select #(.IDLE_CYCLES(200), .OFF_CYCLES(400), .RAMP_CYCLES(20))
    pcm_mode_select_i (
    .clk               (clk),
    .reset_n           (reset_n),
    .shutdown_ctrl_pin (shutdown_ctrl_pin),
    .overcurrent_guard (overcurrent_guard),
    .overtemp_guard    (overtemp_guard),
    .mode_r            (mode_r),
    .power_limit_r     (power_limit_r),
    .no_crack_agc_r    (no_crack_agc_r),
    .amp_enable_r      (amp_enable_r),
    .output_mute_r     (output_mute_r),
    .fault_active_r    (fault_active_r)
  );
  pcm_host pcm_host_i (.clk(clk), .pin(shutdown_ctrl_pin));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic end_sim;
    $display("Checks %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 25000) begin
      error_cnt++;
      $display("ERROR at %0t: timeout", $time);
      end_sim();
    end
  end
  task automatic chk(input logic [2:0] got, input logic [2:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic sel(input int n, input int hi, input int lo);
    pcm_host_i.pulses(n, hi, lo);
    wt(400);
  endtask
  task automatic shut;
    pcm_host_i.off(700);
    #1;
    chk(mode_r, 3'h0);
    chk({no_crack_agc_r, amp_enable_r, output_mute_r}, 3'h1);
  endtask
  task automatic t_modes;
    for (int m = 1; m <= 4; m++) begin
      sel(m, 100, 100);
      chk(mode_r, 3'(m));
      chk({1'b0, power_limit_r}, 3'(m - 1));
      chk({no_crack_agc_r, amp_enable_r, output_mute_r}, 3'h6);
      shut();
    end
  endtask
  task automatic t_latch;
    sel(2, 100, 100);
    sel(3, 100, 100);
    chk(mode_r, 3'h2);
    shut();
    sel(5, 100, 100);
    chk(mode_r, 3'h4);
    shut();
    sel(2, 10, 100);
    chk(mode_r, 3'h1);
    shut();
    sel(2, 100, 10);
    chk(mode_r, 3'h1);
    shut();
  endtask
  task automatic t_fault;
    sel(3, 100, 100);
    for (int g = 0; g < 2; g++) begin
      @(posedge clk) {overtemp_guard, overcurrent_guard} <= 2'(g + 1);
      wt(2);
      chk({fault_active_r, amp_enable_r, output_mute_r}, 3'h5);
      @(posedge clk) {overtemp_guard, overcurrent_guard} <= 2'h0;
      wt(40);
      chk({fault_active_r, amp_enable_r, output_mute_r}, 3'h2);
      chk(mode_r, 3'h3);
    end
    shut();
  endtask
  task automatic t_quick;
    sel(4, 100, 100);
    pcm_host_i.off(410);
    sel(1, 100, 100);
    chk(mode_r, 3'h1);
    chk({no_crack_agc_r, amp_enable_r, output_mute_r}, 3'h6);
    shut();
  endtask
  initial begin
    reset_n <= 1'b0;
    overcurrent_guard <= 1'b0;
    overtemp_guard <= 1'b0;
    wt(8);
    chk({no_crack_agc_r, amp_enable_r, output_mute_r}, 3'h1);
    @(posedge clk) reset_n <= 1'b1;
    t_modes();
    t_latch();
    t_fault();
    t_quick();
    end_sim();
  end
endmodule
